// >>> cpd_defs.svh
// Purpose: constants for the core power-down and clock generator block
// Assumes: one system clock clk_sys at 100 MHz; the oscillator input arrives
//          as a synchronous level sampled on clk_sys
// Notes:   every offset and count used by the design is here; register reset values are literals in the modules
//
// Operation
// - Trigger access enters power-down, cuts core supply
// - Only supervisor data TEST_AND_SET_ACCESS at FF qualifies
// - Power switch released high while powered down
// - Strobes, codes, enable clock high; buses float
// - Reset or interrupt ends power-down, switch low
// - Interrupt release raises release-source flag
// - Interrupt low ends mode, resets core only
// - Interrupt release leaves core mask at level 7
// - Pending interrupt above mask runs its handler
// - Core-only reset negates strobes and codes
// - Interrupt release drives core reset, halt only
// - Divided clock is half oscillator frequency
// - Enable high keeps clocks running in power-down
// - Enable low, switch low: normal running
// - Enable low, switch high: oscillator stops
// - Interrupt wake from stop withholds clock warm-up
// - Warm-up 2^17 cycles delay high, 2^14 low
// - No warm-up on system reset release
// - System reset release keeps flag low
// - Flag-clear input returns flag low
// - Switch low at reset, released on trigger
`ifndef CPD_DEFS_SVH
`define CPD_DEFS_SVH

`define CPD_TRIGGER_ADDR   23'h0000ff
`define CPD_FC_SUPER_DATA  3'h5
`define CPD_CORE_MASK_WAKE 3'h7
`define CPD_WARM_LONG_BITS 5'h11
`define CPD_WARM_SHORT_BITS 5'h0e
`define CPD_CORE_RST_CYC   6'h32

`endif

// >>> cpd_pkg.sv
// Purpose: types shared by the power-down block
// Assumes: cpd_defs.svh holds the numbers
// Notes:   none
`default_nettype none
package cpd_pkg;
  typedef enum logic [1:0] {
    CPD_RUN,
    CPD_DOWN,
    CPD_WAKE
  } cpd_state_e;

  typedef struct packed {
    logic       addrStrobeN;
    logic       upperByteStrobeN;
    logic       lowerByteStrobeN;
    logic       readWrite;
    logic       validPeriphAddrN;
    logic [2:0] functionCodeLines;
    logic       periphEnable;
  } cpd_busctl_s;

  typedef struct packed {
    logic [22:0] addr;
    logic [2:0]  functionCodeLines;
    logic        testAndSetAccess;
    logic        writeStrobe;
  } cpd_access_s;
endpackage : cpd_pkg
`default_nettype wire

// >>> cpd_warmup.sv
// Purpose: warm-up counter over oscillator input edges
// Assumes: oscIn sampled synchronous to clk_sys
// Notes:   done rises once the selected count of oscillator cycles elapsed
`include "cpd_defs.svh"
`default_nettype none
module cpd_warmup
  import cpd_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic clear,
  input  wire logic oscEdge,
  input  wire logic delaySelect,
  output logic      done
);
  logic [17:0] count_q;
  logic [17:0] count_d;
  logic        done_d;
  logic [4:0]  bits;

  always_comb begin
    bits = delaySelect ? `CPD_WARM_LONG_BITS : `CPD_WARM_SHORT_BITS;
    count_d = count_q;
    done_d = count_q[bits];
    if (clear) begin
      count_d = 18'h00000;
      done_d = 1'b0;
    end else if (oscEdge && !count_q[bits]) begin
      count_d = count_q + 18'h00001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 18'h00000;
      done <= 1'b0;
    end else begin
      count_q <= count_d;
      done <= done_d;
    end
  end

  chk_warm_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clear |=> (count_q == 18'h00000) ##1 !done)
    else $error("warm-up counter not cleared");
endmodule : cpd_warmup
`default_nettype wire

// >>> cpd_clkdiv.sv
// Purpose: divide oscillator input by two into the divided clock
// Assumes: oscIn sampled synchronous to clk_sys
// Notes:   output toggles on each rising oscillator edge while enabled
`include "cpd_defs.svh"
`default_nettype none
module cpd_clkdiv
  import cpd_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic oscIn,
  input  wire logic runEnable,
  output logic      oscEdge,
  output logic      divClk
);
  logic oscPrev_q;
  logic div_q;
  logic div_d;

  always_comb begin
    oscEdge = oscIn && !oscPrev_q;
    div_d = div_q;
    if (!runEnable) begin
      div_d = 1'b0;
    end else if (oscEdge) begin
      div_d = !div_q;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oscPrev_q <= 1'b0;
      div_q <= 1'b0;
    end else begin
      oscPrev_q <= oscIn;
      div_q <= div_d;
    end
  end

  assign divClk = div_q;

  chk_div_half: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (runEnable && $past(runEnable) && oscEdge) |=> (div_q != $past(div_q)))
    else $error("divider did not toggle on oscillator edge");
endmodule : cpd_clkdiv
`default_nettype wire

// >>> cpd_power_down.sv
// Purpose: power-down unit and clock generator control
// Assumes: sysResetN is the combined system reset and halt request, low
//          active, synchronous; interrupt inputs synchronous, low active
// Notes:   all outputs registered except corePowerSwitchOut, tied to constant 0; buses float via their enables
`include "cpd_defs.svh"
`default_nettype none
module cpd_power_down
  import cpd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        sysResetN,
  input  wire cpd_access_s coreAccess,
  input  wire cpd_busctl_s coreBusCtl,
  input  wire logic        coreAddrOe,
  input  wire logic        coreDataOe,
  input  wire logic [2:0]  interruptPriorityInputsN,
  input  wire logic        flagClearN,
  input  wire logic        clockEnable,
  input  wire logic        delaySelect,
  input  wire logic        oscillatorInput,
  output cpd_busctl_s      busCtlOut,
  output logic             addrOe,
  output logic             dataOe,
  output logic             corePowerSwitchOut,
  output logic             corePowerSwitchOe,
  output logic             releaseFlag,
  output logic             coreResetOutN,
  output logic             coreHaltOutN,
  output logic [2:0]       coreMaskLevel,
  output logic             dividedClockOut,
  output logic             oscillatorRun
);
  // ****************************************************************
  // State and next values
  // ****************************************************************
  cpd_state_e  state_q;
  cpd_state_e  state_d;
  logic        switchOff_q;
  logic        switchOff_d;
  logic        flag_q;
  logic        flag_d;
  logic [5:0]  coreRstCnt_q;
  logic [5:0]  coreRstCnt_d;
  logic [2:0]  mask_q;
  logic [2:0]  mask_d;
  cpd_busctl_s bus_q;
  cpd_busctl_s bus_d;
  logic        addrOe_q;
  logic        addrOe_d;
  logic        dataOe_q;
  logic        dataOe_d;
  logic        clk_q;
  logic        clk_d;
  logic        run_q;
  logic        run_d;
  logic        swOn_q;
  logic        swOn_d;
  logic        coreRstN_q;
  logic        coreRstN_d;

  logic        trigger;
  logic        irqWake;
  logic        oscEdge;
  logic        divClk;
  logic        warmClear;
  logic        warmDone;
  logic        oscRun;
  logic        coreInReset;

  // ****************************************************************
  // Trigger decode and wake sources
  // ****************************************************************
  assign trigger = coreAccess.testAndSetAccess && coreAccess.writeStrobe
    && (coreAccess.addr == `CPD_TRIGGER_ADDR)
    && (coreAccess.functionCodeLines == `CPD_FC_SUPER_DATA);
  assign irqWake = (interruptPriorityInputsN != 3'h7);
  assign oscRun = clockEnable || !switchOff_q;
  assign coreInReset = (coreRstCnt_q != 6'h00);
  assign warmClear = (state_q == CPD_RUN) && trigger;

  cpd_clkdiv u_clkdiv (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .oscIn     (oscillatorInput),
    .runEnable (oscRun),
    .oscEdge   (oscEdge),
    .divClk    (divClk)
  );

  cpd_warmup u_warmup (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .clear       (warmClear),
    .oscEdge     (oscEdge),
    .delaySelect (delaySelect),
    .done        (warmDone)
  );

  // ****************************************************************
  // Mode sequencing
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    switchOff_d = switchOff_q;
    flag_d = flag_q;
    coreRstCnt_d = coreInReset ? coreRstCnt_q - 6'h01 : coreRstCnt_q;
    mask_d = mask_q;
    if (!sysResetN) begin
      state_d = CPD_RUN;
      switchOff_d = 1'b0;
      flag_d = 1'b0;
      mask_d = `CPD_CORE_MASK_WAKE;
    end else begin
      unique case (state_q)
        CPD_RUN: begin
          if (trigger) begin
            state_d = CPD_DOWN;
            switchOff_d = 1'b1;
          end
        end
        CPD_DOWN: begin
          if (irqWake) begin
            switchOff_d = 1'b0;
            flag_d = 1'b1;
            coreRstCnt_d = `CPD_CORE_RST_CYC;
            mask_d = `CPD_CORE_MASK_WAKE;
            state_d = clockEnable ? CPD_RUN : CPD_WAKE;
          end
        end
        CPD_WAKE: begin
          if (warmDone) begin
            state_d = CPD_RUN;
          end
        end
      endcase
      // Mask reloads coreMaskLevel, its own registered value, once out of reset, so it holds
      if (!coreInReset && state_q == CPD_RUN && !irqWake) begin
        mask_d = coreMaskLevel;
      end
      if (!flagClearN && !(state_q == CPD_DOWN && irqWake)) begin
        flag_d = 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pin levels
  // ****************************************************************
  always_comb begin
    bus_d = coreBusCtl;
    addrOe_d = coreAddrOe;
    dataOe_d = coreDataOe;
    if (state_d == CPD_DOWN) begin
      bus_d = '1;
      addrOe_d = 1'b0;
      dataOe_d = 1'b0;
    end else if (coreRstCnt_d != 6'h00) begin
      bus_d = '1;
      bus_d.periphEnable = coreBusCtl.periphEnable;
      addrOe_d = 1'b0;
      dataOe_d = 1'b1;
    end
    run_d = clockEnable || !switchOff_d;
    swOn_d = !switchOff_d;
    coreRstN_d = (coreRstCnt_d == 6'h00);
    clk_d = (state_q == CPD_RUN || clockEnable) ? divClk : 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CPD_RUN;
      switchOff_q <= 1'b0;
      flag_q <= 1'b0;
      coreRstCnt_q <= 6'h00;
      mask_q <= 3'h7;
      bus_q <= '1;
      addrOe_q <= 1'b0;
      dataOe_q <= 1'b0;
      clk_q <= 1'b0;
      run_q <= 1'b1;
      swOn_q <= 1'b1;
      coreRstN_q <= 1'b1;
    end else begin
      state_q <= state_d;
      switchOff_q <= switchOff_d;
      flag_q <= flag_d;
      coreRstCnt_q <= coreRstCnt_d;
      mask_q <= mask_d;
      bus_q <= bus_d;
      addrOe_q <= addrOe_d;
      dataOe_q <= dataOe_d;
      clk_q <= clk_d;
      run_q <= run_d;
      swOn_q <= swOn_d;
      coreRstN_q <= coreRstN_d;
    end
  end

  assign busCtlOut = bus_q;
  assign addrOe = addrOe_q;
  assign dataOe = dataOe_q;
  assign corePowerSwitchOut = 1'b0;
  assign corePowerSwitchOe = swOn_q;
  assign releaseFlag = flag_q;
  assign coreResetOutN = coreRstN_q;
  assign coreHaltOutN = coreRstN_q;
  assign coreMaskLevel = mask_q;
  assign dividedClockOut = clk_q;
  assign oscillatorRun = run_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_trigger_enter: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == CPD_RUN && trigger && sysResetN) |=> (state_q == CPD_DOWN && !corePowerSwitchOe))
    else $error("trigger did not enter power-down");
  chk_bus_parked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == CPD_DOWN) |-> (busCtlOut == '1 && !addrOe && !dataOe))
    else $error("bus not parked in power-down");
  chk_irq_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == CPD_DOWN && irqWake && sysResetN) |=> (corePowerSwitchOe && releaseFlag && !coreResetOutN && !coreHaltOutN))
    else $error("interrupt release incomplete");
  chk_sys_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !sysResetN |=> (corePowerSwitchOe && !releaseFlag && state_q == CPD_RUN))
    else $error("system reset release wrong");
  chk_flag_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!flagClearN && state_q != CPD_DOWN) |=> !releaseFlag)
    else $error("flag not cleared");
  chk_mask_seven: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == CPD_DOWN && irqWake && sysResetN) |=> coreMaskLevel == 3'h7)
    else $error("mask not seven after release");
  chk_stop_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!clockEnable && switchOff_q && !irqWake && sysResetN)
      |=> !oscillatorRun)
    else $error("oscillator not stopped");
  chk_wake_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state_q == CPD_WAKE && !clockEnable) |=> !dividedClockOut)
    else $error("clock passed during warm-up");
  chk_core_reset_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(coreResetOutN) |-> !coreResetOutN [*8])
    else $error("core reset too short");
  cov_enter: cover property (@(posedge clk_sys) state_q == CPD_DOWN);
  cov_wake: cover property (@(posedge clk_sys) state_q == CPD_WAKE ##1 state_q == CPD_RUN);
  cov_sysrel: cover property (@(posedge clk_sys) state_q == CPD_DOWN ##1 !sysResetN);
endmodule : cpd_power_down
`default_nettype wire

// >>> cpd_core_model.sv
// Purpose: behavioural core bus side feeding the power-down block
// Assumes: core runs on clk_sys; its signals change just after an edge
// Notes:   bus pattern keeps moving so parked outputs cannot pass by luck
`default_nettype none
module cpd_core_model
  import cpd_pkg::*;
(
  input  wire logic clk_sys,
  output cpd_access_s coreAccess,
  output cpd_busctl_s coreBusCtl,
  output logic        coreAddrOe,
  output logic        coreDataOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] phase_q = 8'h00;

  initial coreAccess = '0;
  always @(posedge clk_sys) phase_q <= phase_q + 8'h01;
  assign coreBusCtl = {1'b0, phase_q};
  assign coreAddrOe = ~phase_q[1];
  assign coreDataOe = phase_q[0];

  // One-cycle write access; TEST_AND_SET_ACCESS at FF in supervisor data is the request
  task automatic doAccess(input logic [22:0] addr, input logic [2:0] fc,
                          input logic test_and_set_access);
    @(posedge clk_sys);
    coreAccess <= {addr, fc, test_and_set_access, 1'b1};
    @(posedge clk_sys);
    coreAccess <= '0;
  endtask : doAccess
endmodule : cpd_core_model
`default_nettype wire

// >>> test_cpd_power_down.sv
// Purpose: self-checking bench for the power-down and clock block
// Assumes: oscillator level toggles once per clk_sys while running
// Notes:   delaySelect stays low so warm-up is 2^14 oscillator edges
`include "cpd_defs.svh"
`default_nettype none
module test_cpd_power_down
  import cpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, reset_n = 1'b0, sysResetN = 1'b1;
  logic [2:0]  interruptPriorityInputsN = 3'h7;
  logic        flagClearN = 1'b1, clockEnable = 1'b0;
  logic        delaySelect = 1'b0, oscillatorInput = 1'b0;
  cpd_access_s coreAccess;
  cpd_busctl_s coreBusCtl, busCtlOut;
  logic        coreAddrOe, coreDataOe, addrOe, dataOe;
  logic        corePowerSwitchOut, corePowerSwitchOe, releaseFlag;
  logic        coreResetOutN, coreHaltOutN, dividedClockOut, oscillatorRun;
  logic [2:0]  coreMaskLevel;
  int          failures = 0, samples_checked = 0;

  always #5 clk_sys = ~clk_sys;
  // Oscillator stands still while the block stops it
  always @(posedge clk_sys) if (oscillatorRun) oscillatorInput <= ~oscillatorInput;

  cpd_core_model u_cpd_core_model (.clk_sys, .coreAccess, .coreBusCtl,
                                   .coreAddrOe, .coreDataOe);
  cpd_power_down u_cpd_power_down (.clk_sys, .reset_n, .sysResetN,
    .coreAccess, .coreBusCtl, .coreAddrOe, .coreDataOe,
    .interruptPriorityInputsN, .flagClearN, .clockEnable, .delaySelect,
    .oscillatorInput, .busCtlOut, .addrOe, .dataOe, .corePowerSwitchOut,
    .corePowerSwitchOe, .releaseFlag, .coreResetOutN, .coreHaltOutN,
    .coreMaskLevel, .dividedClockOut, .oscillatorRun);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic enterDown;
    // Nothing to save in the model core before the trigger
    u_cpd_core_model.doAccess(`CPD_TRIGGER_ADDR, `CPD_FC_SUPER_DATA, 1'b1);
    tick(1);
  endtask : enterDown

  task automatic wake;
    @(posedge clk_sys);
    interruptPriorityInputsN <= 3'h6;
    tick(2);
  endtask : wake

  task automatic countToggles(input int n, output int t);
    logic p;
    t = 0;
    repeat (n) begin
      p = dividedClockOut;
      tick(1);
      if (dividedClockOut !== p) t++;
    end
  endtask : countToggles

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testReset;
    check(corePowerSwitchOe, 1'b1);
    check(corePowerSwitchOut, 1'b0);
    check(releaseFlag, 1'b0);
    check(coreResetOutN, 1'b1);
    $display("test reset done");
  endtask : testReset

  task automatic testRefuse;
    logic [22:0] ad [4] = '{23'h0000fe, 23'h0000ff, 23'h0000ff, 23'h0000ff};
    logic [2:0]  fc [4] = '{3'h5, 3'h1, 3'h6, 3'h5};
    logic        ts [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      u_cpd_core_model.doAccess(ad[i], fc[i], ts[i]);
      tick(2);
      check(corePowerSwitchOe, 1'b1);
    end
    $display("test refuse done");
  endtask : testRefuse

  task automatic testFreeRun;
    int t;
    int k;
    @(posedge clk_sys);
    clockEnable <= 1'b1;
    enterDown();
    check(corePowerSwitchOe, 1'b0);
    check(busCtlOut, 9'h1ff);
    check({addrOe, dataOe}, 2'h0);
    countToggles(40, t);
    check(t >= 19 && t <= 21, 1'b1);
    check(busCtlOut, 9'h1ff);
    wake();
    check(corePowerSwitchOe, 1'b1);
    check(releaseFlag, 1'b1);
    check({coreResetOutN, coreHaltOutN}, 2'h0);
    check(coreMaskLevel, 3'h7);
    check(busCtlOut[8:1], 8'hff);
    check(addrOe, 1'b0);
    @(posedge clk_sys);
    interruptPriorityInputsN <= 3'h7;
    tick(44);
    check(coreResetOutN, 1'b0);
    k = 0;
    while (coreResetOutN !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    check(coreResetOutN, 1'b1);
    @(posedge clk_sys);
    flagClearN <= 1'b0;
    tick(2);
    check(releaseFlag, 1'b0);
    @(posedge clk_sys);
    flagClearN <= 1'b1;
    $display("test free run done");
  endtask : testFreeRun

  task automatic testSysReset;
    int t;
    @(posedge clk_sys);
    clockEnable <= 1'b0;
    enterDown();
    tick(1);
    check(oscillatorRun, 1'b0);
    @(posedge clk_sys);
    sysResetN <= 1'b0;
    tick(2);
    check(corePowerSwitchOe, 1'b1);
    check(releaseFlag, 1'b0);
    tick(50);
    @(posedge clk_sys);
    sysResetN <= 1'b1;
    tick(2);
    check(oscillatorRun, 1'b1);
    countToggles(40, t);
    check(t >= 15, 1'b1);
    check(releaseFlag, 1'b0);
    $display("test system reset done");
  endtask : testSysReset

  task automatic testWarmup;
    logic hi;
    int   k;
    hi = 1'b0;
    enterDown();
    wake();
    @(posedge clk_sys);
    interruptPriorityInputsN <= 3'h7;
    tick(1);
    check(oscillatorRun, 1'b1);
    repeat (32000) begin
      tick(1);
      hi |= dividedClockOut;
    end
    check(hi, 1'b0);
    k = 0;
    while (dividedClockOut !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    check(dividedClockOut, 1'b1);
    $display("test warm-up done");
  endtask : testWarmup

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    tick(2);
    testReset();
    testRefuse();
    testFreeRun();
    testSysReset();
    testWarmup();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end
endmodule : test_cpd_power_down
`default_nettype wire
